// file: hw/clocked_serial_unit.v
// Behaviour
// RULE1: Stopped, single-byte and automatic modes only
// RULE2: Stopped mode runs no serial activity
// RULE3: Disabled: data out low, clock high
// RULE4: Auto bit clear: one byte per start
// RULE5: Three wires: clock, data out, in
// RULE6: Reset clears mode and status registers
// RULE7: Status bits 7:6 pick base divide 1/2/4/8
// RULE8: Divisor field divides by 6/8/16/32
// RULE9: Busy reads 1 from start to end
// RULE10: Busy 0 disabled, reset, done, stopped
// RULE11: Busy flag is read-only to software
// RULE12: Software avoids register writes while busy
// RULE13: Buffer memory writes accepted while busy
// RULE14: Software writes zeros to status bits 5:1
// RULE15: Master drives clock, slave uses input
// RULE16: Tx off holds low, rx off ignores
// RULE17: Shift write while enabled and idle starts
// RULE18: After eight bits stop and raise irq
// RULE19: Eight bits, output changes on falling
// RULE20: Bit order reversed at write and read
`include "serial_core_defines.vh"
`default_nettype none

module clocked_serial_unit (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [31:0] reg_addr,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata_ff,
  input  wire        serial_clock_pin_in,
  output wire        serial_clock_pin_out,
  output wire        serial_clock_pin_oe,
  output reg         serial_out_pin_ff,
  input  wire        serial_in_pin,
  output reg         transfer_done_irq_ff,
  output wire        auto_transfer_enable
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  reg  [7:0] serial_mode_ctrl_ff;
  reg  [1:0] base_sel_ff;
  reg  [1:0] div_sel_ff;
  reg  [7:0] shift_data_ff;
  reg        transfer_busy_flag_ff;
  reg  [2:0] bit_cnt_ff;
  reg        sck_in_prev_ff;
  reg  [7:0] rd_mux;
  wire       unit_en;
  wire       master;
  wire       tx_en;
  wire       rx_en;
  wire       lsb_first;
  wire       wr_mode;
  wire       wr_status;
  wire       wr_div;
  wire       wr_trig;
  wire       wr_shift;
  wire       start;
  wire       stop_req;
  wire       gen_sck;
  wire       gen_fall;
  wire       gen_rise;
  wire       fall_edge;
  wire       rise_edge;
  wire       last_bit;

  // ------------------------------------------------------------
  // Bit-order reversal, used on write and on read
  // ------------------------------------------------------------
  function [7:0] order_bits;
    input [7:0] data;
    input       reverse;
    integer     i;
    begin
      order_bits = data;
      if (reverse) begin
        for (i = 0; i < 8; i = i + 1) begin
          order_bits[i] = data[7 - i];
        end
      end
    end
  endfunction

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  assign unit_en              = serial_mode_ctrl_ff[`MODE_UNIT_EN];
  assign master               = serial_mode_ctrl_ff[`MODE_MASTER];
  assign tx_en                = serial_mode_ctrl_ff[`MODE_TX_EN];
  assign rx_en                = serial_mode_ctrl_ff[`MODE_RX_EN];
  assign lsb_first            = serial_mode_ctrl_ff[`MODE_BIT_ORDER];
  // Automatic multi-byte engine sits outside; it sees this bit
  assign auto_transfer_enable = unit_en & serial_mode_ctrl_ff[`MODE_AUTO_EN]; // RULE1

  // ------------------------------------------------------------
  // Write strobes
  // ------------------------------------------------------------
  // No busy lock on writes except shift data, which is dropped while busy; buffer memory outside stays writable
  assign wr_mode   = reg_wr && (reg_addr == `ADDR_MODE_CTRL); // RULE13
  assign wr_status = reg_wr && (reg_addr == `ADDR_STATUS);
  assign wr_div    = reg_wr && (reg_addr == `ADDR_DIVISOR);
  assign wr_trig   = reg_wr && (reg_addr == `ADDR_TRIGGER);
  assign wr_shift  = reg_wr && (reg_addr == `ADDR_SHIFT_DATA);
  assign stop_req  = wr_trig && reg_wdata[`TRIG_STOP];

  // Enabling after the data write never starts a transfer, since
  // only the write itself is the trigger.
  assign start = wr_shift && unit_en && !transfer_busy_flag_ff
                 && !serial_mode_ctrl_ff[`MODE_AUTO_EN]; // RULE17 RULE4

  // ------------------------------------------------------------
  // Internal transfer clock
  // ------------------------------------------------------------
  serial_clock_gen u_clk_gen (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .run          (transfer_busy_flag_ff & master & unit_en), // RULE2
    .base_sel     (base_sel_ff),   // RULE7
    .div_sel      (div_sel_ff),    // RULE8
    .sck_ff       (gen_sck),
    .fall_tick_ff (gen_fall),
    .rise_tick_ff (gen_rise)
  );

  // ------------------------------------------------------------
  // Edge source: internal ticks or the peer's clock input
  // ------------------------------------------------------------
  assign fall_edge = master ? gen_fall
                            : (sck_in_prev_ff && !serial_clock_pin_in); // RULE15
  assign rise_edge = master ? gen_rise
                            : (!sck_in_prev_ff && serial_clock_pin_in);
  assign last_bit  = (bit_cnt_ff == `LAST_BIT);

  // Clock pin: driven high when disabled, internal clock in master
  assign serial_clock_pin_out = (unit_en && master) ? gen_sck : 1'b1; // RULE3 RULE15
  assign serial_clock_pin_oe  = !unit_en || master;                   // RULE5

  // ------------------------------------------------------------
  // Slave clock history; pin is taken as synchronous
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      sck_in_prev_ff <= 1'b1;
    end else begin
      sck_in_prev_ff <= serial_clock_pin_in;
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      serial_mode_ctrl_ff <= `RST_BYTE;  // RULE6
      base_sel_ff         <= `RST_CKS;   // RULE6
      div_sel_ff          <= `RST_DIV;
    end else begin
      if (wr_mode) begin
        serial_mode_ctrl_ff <= reg_wdata & `MODE_WR_MASK;
      end
      // Only the clock select is writable here
      if (wr_status) begin
        base_sel_ff <= reg_wdata[`STAT_CKS_HI:`STAT_CKS_LO]; // RULE11 RULE14
      end
      if (wr_div) begin
        div_sel_ff <= reg_wdata[`DIV_FIELD_HI:`DIV_FIELD_LO];
      end
    end
  end

  // ------------------------------------------------------------
  // Transfer engine: shift left, MSB of register leaves first
  // ------------------------------------------------------------
  always @(posedge clk) begin
    transfer_done_irq_ff <= 1'b0;
    if (sys_rst) begin
      shift_data_ff         <= `RST_BYTE;
      transfer_busy_flag_ff <= 1'b0;           // RULE10
      bit_cnt_ff            <= `RST_BITS;
      serial_out_pin_ff     <= 1'b0;
    end else if (!unit_en) begin
      transfer_busy_flag_ff <= 1'b0;           // RULE10
      bit_cnt_ff            <= `RST_BITS;
      serial_out_pin_ff     <= 1'b0;           // RULE3
    end else if (stop_req) begin
      transfer_busy_flag_ff <= 1'b0;           // RULE10
      bit_cnt_ff            <= `RST_BITS;
    end else if (start) begin
      shift_data_ff         <= order_bits(reg_wdata, lsb_first); // RULE20
      transfer_busy_flag_ff <= 1'b1;           // RULE9
      bit_cnt_ff            <= `RST_BITS;
    end else if (transfer_busy_flag_ff) begin
      if (fall_edge) begin
        serial_out_pin_ff <= tx_en & shift_data_ff[7]; // RULE19 RULE16
      end
      if (rise_edge) begin
        // Receive off keeps the line out of the register
        shift_data_ff <= {shift_data_ff[6:0], rx_en & serial_in_pin}; // RULE16
        bit_cnt_ff    <= bit_cnt_ff + `BIT_STEP;
        if (last_bit) begin
          transfer_busy_flag_ff <= 1'b0;       // RULE18 RULE10
          transfer_done_irq_ff  <= 1'b1;       // RULE18
        end
      end
    end
    if (!tx_en) begin
      serial_out_pin_ff <= 1'b0;               // RULE16
    end
  end

  // ------------------------------------------------------------
  // Read path; unmapped addresses read zero
  // ------------------------------------------------------------
  always @* begin
    rd_mux = `RST_BYTE;
    case (reg_addr)
      `ADDR_MODE_CTRL:  rd_mux = serial_mode_ctrl_ff;
      `ADDR_STATUS:     rd_mux = {base_sel_ff, 5'h00, transfer_busy_flag_ff}; // RULE9
      `ADDR_DIVISOR:    rd_mux = {6'h00, div_sel_ff};                        // RULE8
      `ADDR_SHIFT_DATA: rd_mux = order_bits(shift_data_ff, lsb_first);       // RULE20
      default:          rd_mux = `RST_BYTE;
    endcase
  end

  // Registered read data, one cycle after the strobe
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata_ff <= `RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata_ff <= rd_mux;
    end
  end

endmodule

`default_nettype wire

// file: hw/serial_clock_gen.v
`include "serial_core_defines.vh"
`default_nettype none

module serial_clock_gen (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       run,
  input  wire [1:0] base_sel,
  input  wire [1:0] div_sel,
  output reg        sck_ff,
  output reg        fall_tick_ff,
  output reg        rise_tick_ff
);

  reg  [7:0] cnt_ff;
  reg  [7:0] half_div;
  wire [7:0] half_len;

  // ------------------------------------------------------------
  // Half period in clk cycles: base (1,2,4,8) times ratio / 2
  // ------------------------------------------------------------
  always @* begin
    case (div_sel)
      2'h0:    half_div = `HALF_DIV6;
      2'h1:    half_div = `HALF_DIV8;
      2'h2:    half_div = `HALF_DIV16;
      default: half_div = `HALF_DIV32;
    endcase
  end
  assign half_len = half_div << base_sel;

  // ------------------------------------------------------------
  // Clock toggles every half period; idles high when stopped
  // ------------------------------------------------------------
  always @(posedge clk) begin
    fall_tick_ff <= 1'b0;
    rise_tick_ff <= 1'b0;
    if (sys_rst || !run) begin
      cnt_ff <= `CNT_ZERO;
      sck_ff <= 1'b1;
    end else if (cnt_ff == half_len - `CNT_STEP) begin
      cnt_ff       <= `CNT_ZERO;
      sck_ff       <= ~sck_ff;
      fall_tick_ff <= sck_ff;   // RULE15
      rise_tick_ff <= ~sck_ff;
    end else begin
      cnt_ff <= cnt_ff + `CNT_STEP;
    end
  end

endmodule

`default_nettype wire

// file: hw/serial_core_defines.vh
`ifndef SERIAL_CORE_DEFINES_VH
`define SERIAL_CORE_DEFINES_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_MODE_CTRL      32'hFFFFFD40
`define ADDR_STATUS         32'hFFFFFD41
`define ADDR_DIVISOR        32'hFFFFFD42
`define ADDR_TRIGGER        32'hFFFFFD43
`define ADDR_SHIFT_DATA     32'hFFFFFD44

// ----------------------------------------------------------------
// Mode control fields
// ----------------------------------------------------------------
`define MODE_UNIT_EN        7
`define MODE_AUTO_EN        6
`define MODE_REPEAT         5
`define MODE_MASTER         4
`define MODE_TX_EN          3
`define MODE_RX_EN          2
`define MODE_BIT_ORDER      1
`define MODE_WR_MASK        8'hFE

// ----------------------------------------------------------------
// Status, divisor and trigger fields
// ----------------------------------------------------------------
`define STAT_CKS_HI         7
`define STAT_CKS_LO         6
`define STAT_BUSY           0
`define DIV_FIELD_HI        1
`define DIV_FIELD_LO        0
`define TRIG_STOP           0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define RST_BYTE            8'h00
`define RST_CKS             2'h0
`define RST_DIV             2'h0
`define RST_BITS            3'h0
`define LAST_BIT            3'h7
`define BIT_STEP            3'h1

// Half of the divide ratios 6, 8, 16, 32
`define HALF_DIV6           8'h03
`define HALF_DIV8           8'h04
`define HALF_DIV16          8'h08
`define HALF_DIV32          8'h10
`define CNT_ZERO            8'h00
`define CNT_STEP            8'h01

`endif

// file: verif/clocked_serial_unit_assertions.sv
`include "serial_core_defines.vh"
`default_nettype none
module clocked_serial_unit_assertions (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [31:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata_ff,
  input wire logic        serial_clock_pin_out,
  input wire logic        serial_clock_pin_oe,
  input wire logic        serial_out_pin_ff,
  input wire logic        transfer_done_irq_ff,
  input wire logic        auto_transfer_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mode_ff;
  logic [7:0] mode_d1_ff;
  logic [7:0] mode_d2_ff;
  // Shadow of the mode register, followed from bus writes, with history
  always @(posedge clk) begin
    if (sys_rst) begin
      mode_ff    <= 8'h00;
      mode_d1_ff <= 8'h00;
      mode_d2_ff <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `ADDR_MODE_CTRL) mode_ff <= reg_wdata;
      mode_d1_ff <= mode_ff;
      mode_d2_ff <= mode_d1_ff;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Mode settled for two cycles, so registered outputs have caught up
  wire logic settled = (mode_ff == mode_d1_ff) && (mode_ff == mode_d2_ff);
  property p_rst_idle;
    $fell(sys_rst) |-> serial_clock_pin_out && serial_clock_pin_oe && !serial_out_pin_ff
      && !transfer_done_irq_ff;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("idle levels wrong after reset");
  property p_stat_zero;
    reg_rd && reg_addr == `ADDR_STATUS |=> reg_rdata_ff[5:1] == 5'h00;
  endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("status bits 5:1 not zero");
  property p_disable_idle;
    reg_wr && reg_addr == `ADDR_MODE_CTRL && !reg_wdata[7] |=> ##1
      serial_clock_pin_out && serial_clock_pin_oe && !serial_out_pin_ff;
  endproperty
  a_disable_idle: assert property (p_disable_idle) else $error("disabled pins wrong");
  property p_slave_clk;
    mode_ff[7] && !mode_ff[4] && $stable(mode_ff) |-> !serial_clock_pin_oe;
  endproperty
  a_slave_clk: assert property (p_slave_clk) else $error("slave drives clock");
  property p_irq_pulse;
    transfer_done_irq_ff |=> !transfer_done_irq_ff;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("done pulse too long");
  property p_out_on_fall;
    mode_ff[7] && mode_ff[4] && settled && $changed(serial_out_pin_ff)
      |-> $past(serial_clock_pin_out) == 1'b0;
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("data moved off fall");
  property p_tx_off;
    mode_ff[7] && !mode_ff[3] && settled |-> !serial_out_pin_ff;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("data out high with tx off");
  property p_no_start;
    reg_wr && reg_addr == `ADDR_SHIFT_DATA && !mode_ff[7] |=> serial_clock_pin_out [*8];
  endproperty
  a_no_start: assert property (p_no_start) else $error("clock ran while disabled");
  property p_stop_no_irq;
    reg_wr && reg_addr == `ADDR_TRIGGER && reg_wdata[0] |=> !transfer_done_irq_ff [*3];
  endproperty
  a_stop_no_irq: assert property (p_stop_no_irq) else $error("done after stop");
  property p_auto_flag;
    auto_transfer_enable == (mode_ff[7] && mode_ff[6]);
  endproperty
  a_auto_flag: assert property (p_auto_flag) else $error("auto flag wrong");
  c_done: cover property (transfer_done_irq_ff);
  c_slave: cover property (mode_ff[7] && !serial_clock_pin_oe);
  c_stop: cover property (reg_wr && reg_addr == `ADDR_TRIGGER && reg_wdata[0]);
  c_slave_done: cover property (transfer_done_irq_ff && !serial_clock_pin_oe);
endmodule
bind clocked_serial_unit clocked_serial_unit_assertions u_chk (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff), .serial_clock_pin_out(serial_clock_pin_out),
  .serial_clock_pin_oe(serial_clock_pin_oe), .serial_out_pin_ff(serial_out_pin_ff),
  .transfer_done_irq_ff(transfer_done_irq_ff), .auto_transfer_enable(auto_transfer_enable));
`default_nettype wire

// file: verif/serial_peer_model.sv
`default_nettype none
module serial_peer_model (
  input  wire logic       clk,
  input  wire logic       sck,
  input  wire logic       so,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output var  logic       si,
  output var  logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  int   n = 8;
  logic sck_q = 1'b1;
  // Clock edges seen one clk late; peer data moves on a fall, MSB first,
  // device data taken on a rise. Outside a frame the line wanders, so a
  // late sample never looks valid.
  always @(posedge clk) begin
    sck_q <= sck;
    if (load) begin
      n  <= 0;
      si <= 1'b0;
    end else if (n >= 8) begin
      si <= ~si;
    end else if (sck_q && !sck) begin
      si <= tx_byte[7 - n];
    end else if (!sck_q && sck) begin
      rx_byte <= {rx_byte[6:0], so};
      n       <= n + 1;
    end
  end
endmodule
`default_nettype wire

// file: verif/tb_clocked_serial_unit.sv
`include "serial_core_defines.vh"
`default_nettype none
module tb_clocked_serial_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, load = 0;
  logic [31:0] reg_addr = 0;
  logic [7:0]  reg_wdata = 0, peer_tx = 0, rdata, peer_rx;
  logic [7:0]  hv [4] = '{8'h03, 8'h04, 8'h08, 8'h10};
  wire logic   sck_out, sck_oe, so, si, irq, auto_en;
  // Bench is the clock source while the device is slave; idles high
  logic        ext_sck = 1;
  wire logic   sck_wire = sck_oe ? sck_out : ext_sck;
  int          bad_count = 0, check_count = 0, w;
  always #12.5 clk = ~clk;
  clocked_serial_unit dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(rdata), .serial_clock_pin_in(sck_wire),
    .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe), .serial_out_pin_ff(so),
    .serial_in_pin(si), .transfer_done_irq_ff(irq), .auto_transfer_enable(auto_en));
  serial_peer_model peer (.clk(clk), .sck(sck_wire), .so(so), .load(load), .tx_byte(peer_tx),
    .si(si), .rx_byte(peer_rx));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [31:0] a, input logic [7:0] d);
    @(negedge clk); reg_addr = a; reg_wdata = d; reg_wr = 1;
    @(negedge clk); reg_wr = 0;
  endtask
  task rd(input logic [31:0] a, input logic [7:0] e);
    @(negedge clk); reg_addr = a; reg_rd = 1;
    @(negedge clk); reg_rd = 0;
    @(negedge clk); chk(rdata, e);
  endtask
  function logic [7:0] rev(input logic [7:0] d);
    for (int i = 0; i < 8; i++) rev[i] = d[7 - i];
  endfunction
  task end_of_test;
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One full byte: measure low phase, check busy, flag, both bytes
  task xfer(input logic [7:0] m, input logic [1:0] cks, input logic [1:0] dv,
            input logic [7:0] d, input logic [7:0] pb);
    int n;
    int h;
    wr(`ADDR_MODE_CTRL, 8'h00);
    wr(`ADDR_STATUS, {cks, 6'h00});
    wr(`ADDR_DIVISOR, {6'h00, dv});
    wr(`ADDR_MODE_CTRL, m);
    peer_tx = pb;
    load = 1;
    @(negedge clk);
    load = 0;
    wr(`ADDR_SHIFT_DATA, d);
    n = 0; while (sck_out && n < 300) begin @(negedge clk); n++; end
    h = 0; while (!sck_out && h < 300) begin @(negedge clk); h++; end
    chk(h[7:0], hv[dv] << cks);
    rd(`ADDR_STATUS, {cks, 5'h00, 1'b1});
    n = 0; while (!irq && n < 5000) begin @(negedge clk); n++; end
    chk({7'h00, irq}, 8'h01);
    if (!irq) end_of_test;
    rd(`ADDR_STATUS, {cks, 6'h00});
    rd(`ADDR_SHIFT_DATA, m[2] ? (m[1] ? rev(pb) : pb) : 8'h00);
    chk(peer_rx, m[3] ? (m[1] ? rev(d) : d) : 8'h00);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 0;
    rd(`ADDR_MODE_CTRL, 8'h00);
    rd(`ADDR_STATUS, 8'h00);
    rd(32'hFFFFFD50, 8'h00);
    wr(`ADDR_DIVISOR, 8'hFF);
    rd(`ADDR_DIVISOR, 8'h03);
    wr(`ADDR_STATUS, 8'hC1);
    rd(`ADDR_STATUS, 8'hC0);
    wr(`ADDR_SHIFT_DATA, 8'hA5);
    wr(`ADDR_MODE_CTRL, 8'h9C);
    rd(`ADDR_STATUS, 8'hC0);
    wr(`ADDR_MODE_CTRL, 8'hDC);
    chk({7'h00, auto_en}, 8'h01);
    wr(`ADDR_SHIFT_DATA, 8'h5A);
    rd(`ADDR_STATUS, 8'hC0);
    for (int i = 0; i < 16; i++) begin
      xfer(8'h9C, i[3:2], i[1:0], 8'hA5 ^ i[7:0], 8'h3C + i[7:0]);
    end
    xfer(8'h9E, 2'h0, 2'h1, 8'h01, 8'hC4);
    xfer(8'h94, 2'h1, 2'h0, 8'hFF, 8'h96);
    xfer(8'h98, 2'h0, 2'h0, 8'h81, 8'h7E);
    wr(`ADDR_MODE_CTRL, 8'h9C);
    wr(`ADDR_SHIFT_DATA, 8'h55);
    wr(`ADDR_TRIGGER, 8'h01);
    rd(`ADDR_STATUS, 8'h00);
    wr(`ADDR_MODE_CTRL, 8'h8C);
    rd(`ADDR_MODE_CTRL, 8'h8C);
    // Slave byte: bench clocks the line, four clk cycles a phase
    peer_tx = 8'h69;
    load = 1;
    @(negedge clk);
    load = 0;
    wr(`ADDR_SHIFT_DATA, 8'hB2);
    chk({7'h00, sck_oe}, 8'h00);
    for (int b = 0; b < 8; b++) begin
      ext_sck = 0;
      repeat (4) @(negedge clk);
      ext_sck = 1;
      if (b < 7) repeat (4) @(negedge clk);
    end
    w = 0;
    while (!irq && w < 8) begin
      @(negedge clk);
      w++;
    end
    chk({7'h00, irq}, 8'h01);
    rd(`ADDR_STATUS, 8'h00);
    rd(`ADDR_SHIFT_DATA, 8'h69);
    chk(peer_rx, 8'hB2);
    wr(`ADDR_MODE_CTRL, 8'h00);
    rd(`ADDR_STATUS, 8'h00);
    end_of_test;
  end
endmodule
`default_nettype wire
